// ==== src/fbg_defines.svh ====
// Constants for the flash boot select and ID guard
`ifndef FBG_DEFINES_SVH
`define FBG_DEFINES_SVH
`define FBG_SIG_WORD      64'h55736572426f6f74
`define FBG_ERASE_WORD    56'h414c6552415345
`define FBG_PROTECT_WORD  56'h50726f74656374
`define FBG_PORT_NONE     16'h0000
`define FBG_PORT_A        16'h03e9
`define FBG_PORT_B        16'h03ec
`define FBG_PORT_C        16'h03ed
`define FBG_PORT_D        16'h03f0
`define FBG_PORT_E        16'h03f4
`define FBG_LEVEL_HIGH    8'h00
`define FBG_LEVEL_LOW     8'h01
`define FBG_BIT_MAX       8'h07
`define FBG_USER_START    20'h10000
`define FBG_SERIAL_START  20'h00000
`define FBG_VECTOR_BLANK  32'hffffffff
`define FBG_OPT_PROTECT   3
`define FBG_ERASED_BYTE   8'hff
`define FBG_DF_LO         20'h0e000
`define FBG_DF_HI         20'h0ffff
`define FBG_ROM2_LO       20'h10000
`define FBG_ROM2_HI       20'h13fff
`endif

// ==== src/fbg_pkg.sv ====
// Types for the flash boot select and ID guard
`default_nettype none
package fbg_pkg;
	typedef enum logic [1:0] {FBG_MODE_NONE, FBG_MODE_SERIAL, FBG_MODE_USER, FBG_MODE_NORMAL} fbg_mode_t;
	typedef struct packed {
		logic [63:0] signature;
		logic [15:0] port_addr;
		logic [7:0]  port_bit;
		logic [7:0]  port_level;
		logic [55:0] stored_id;
		logic [31:0] reset_vector;
		logic [7:0]  option_byte;
	} fbg_flash_info_t;
	typedef struct packed {
		logic        accept;
		logic        reject;
		logic        erase_all;
		logic        serial_off;
	} fbg_id_result_t;
endpackage
`default_nettype wire

// ==== src/fbg_id_compare.sv ====
// Combinational ID code comparison against stored and reserved words
`include "fbg_defines.svh"
`default_nettype none
module fbg_id_compare (
	input  wire logic [55:0]          i_rx_id,
	input  wire logic [55:0]          i_stored_id,
	input  wire logic [31:0]          i_reset_vector,
	input  wire logic                 i_protect_on,
	output fbg_pkg::fbg_id_result_t   o_result
);
	import fbg_pkg::*;
	logic [6:0] byte_eq;
	logic       all_eq;
	logic       rx_erase;
	logic       st_erase;
	logic       st_protect;
	logic       blank;
	// Per-byte equality, in order
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : g_byte
			assign byte_eq[g] = (i_rx_id[8*g +: 8] == i_stored_id[8*g +: 8]);
		end
	endgenerate
	assign all_eq     = &byte_eq;
	assign rx_erase   = (i_rx_id == `FBG_ERASE_WORD);
	assign st_erase   = (i_stored_id == `FBG_ERASE_WORD);
	assign st_protect = (i_stored_id == `FBG_PROTECT_WORD);
	assign blank      = (i_reset_vector == `FBG_VECTOR_BLANK);
	// Decision order: serial off, forced erase, blank vector, ID check
	always_comb begin
		o_result = '0;
		if (st_protect) begin
			o_result.serial_off = 1'b1;
			o_result.reject     = 1'b1;
		end else if (rx_erase && (st_erase || !i_protect_on)) begin
			o_result.erase_all = 1'b1;
			o_result.accept    = 1'b1;
		end else if (blank) begin
			o_result.accept = 1'b1;
		end else if (all_eq && !st_erase) begin
			o_result.accept = 1'b1;
		end else begin
			o_result.reject = 1'b1;
		end
	end
endmodule // fbg_id_compare
`default_nettype wire

// ==== src/fbg_guard.sv ====
// Boot mode selection and flash access guard
`include "fbg_defines.svh"
`default_nettype none
module fbg_guard #(
	parameter int ID_BYTES = 7,
	parameter bit LARGE_PACKAGE = 1'b1
) (
	input  wire logic                     i_clk_sys,
	input  wire logic                     i_reset_n,
	input  wire logic                     i_boot_select_pin,
	input  wire logic                     i_processor_mode_pin,
	input  wire fbg_pkg::fbg_flash_info_t i_flash,
	input  wire logic [7:0]               i_port_a,
	input  wire logic [7:0]               i_port_b,
	input  wire logic [7:0]               i_port_c,
	input  wire logic [7:0]               i_port_d,
	input  wire logic [7:0]               i_port_e,
	input  wire logic                     i_id_valid,
	input  wire logic [8*ID_BYTES-1:0]    i_rx_id,
	input  wire logic                     i_cmd_valid,
	input  wire logic                     i_par_req,
	input  wire logic                     i_block0_erased,
	input  wire logic                     i_rom2_enable_bit,
	input  wire logic                     i_data_flash_map_bit,
	input  wire logic [19:0]              i_cpu_addr,
	output logic                          o_boot_done,
	output fbg_pkg::fbg_mode_t            o_mode,
	output logic [19:0]                   o_start_addr,
	output logic                          o_cmd_accept,
	output logic                          o_cmd_reject,
	output logic                          o_erase_all,
	output logic                          o_serial_off,
	output logic                          o_id_checked,
	output logic                          o_par_grant,
	output logic                          o_par_refuse,
	output logic                          o_protect_on,
	output logic                          o_rom2_sel,
	output logic                          o_data_flash_sel
);
	import fbg_pkg::*;

	logic           rst_s1;
	logic           rst_n;
	logic           decided;
	logic           port_ok;
	logic [7:0]     port_val;
	logic           pin_lvl;
	logic           sig_ok;
	fbg_mode_t      next_mode;
	logic           protect_on;
	fbg_id_result_t id_res;
	logic           id_pass;

	// Reset release synchroniser
	always_ff @(posedge i_clk_sys or negedge i_reset_n) begin
		if (!i_reset_n) begin
			rst_s1 <= 1'b0;
			rst_n  <= 1'b0;
		end else begin
			rst_s1 <= 1'b1;
			rst_n  <= rst_s1;
		end
	end

	// Entry port lookup
	always_comb begin
		port_ok  = 1'b1;
		port_val = 8'h00;
		case (i_flash.port_addr)
			`FBG_PORT_A: port_val = i_port_a;
			`FBG_PORT_B: port_val = i_port_b;
			`FBG_PORT_C: port_val = i_port_c;
			`FBG_PORT_D: port_val = i_port_d;
			`FBG_PORT_E: begin
				port_val = i_port_e;
				port_ok  = LARGE_PACKAGE;
			end
			default: port_ok = 1'b0;
		endcase
		if (i_flash.port_bit > `FBG_BIT_MAX)
			port_ok = 1'b0;
	end

	assign pin_lvl = port_val[i_flash.port_bit[2:0]];
	assign sig_ok  = (i_flash.signature == `FBG_SIG_WORD);

	// Start mode decision
	always_comb begin
		next_mode = FBG_MODE_SERIAL;
		if (!(!i_boot_select_pin && i_processor_mode_pin)) begin
			next_mode = FBG_MODE_NORMAL;
		end else if (!sig_ok) begin
			next_mode = FBG_MODE_SERIAL;
		end else if (i_flash.port_addr == `FBG_PORT_NONE && i_flash.port_bit == 8'h00
			&& i_flash.port_level == `FBG_LEVEL_HIGH) begin
			next_mode = FBG_MODE_USER;
		end else if (port_ok && i_flash.port_level == `FBG_LEVEL_HIGH) begin
			next_mode = pin_lvl ? FBG_MODE_SERIAL : FBG_MODE_USER;
		end else if (port_ok && i_flash.port_level == `FBG_LEVEL_LOW) begin
			next_mode = pin_lvl ? FBG_MODE_USER : FBG_MODE_SERIAL;
		end else begin
			next_mode = FBG_MODE_SERIAL; // Illegal combination falls back
		end
	end

	// Decision taken once after reset release and held
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			decided      <= 1'b0;
			o_boot_done  <= 1'b0;
			o_mode       <= FBG_MODE_NONE;
			o_start_addr <= `FBG_SERIAL_START;
		end else if (!decided) begin
			decided      <= 1'b1;
			o_boot_done  <= 1'b1;
			o_mode       <= next_mode;
			o_start_addr <= (next_mode == FBG_MODE_USER) ? `FBG_USER_START : `FBG_SERIAL_START;
		end
	end

	// Parallel protection, lifted by erasing the option byte block
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			protect_on <= 1'b0;
		end else if (i_block0_erased) begin
			// Erased option byte reads all ones, so its protect bit says off
			protect_on <= ~|(`FBG_ERASED_BYTE & (8'h01 << `FBG_OPT_PROTECT));
		end else if (!decided) begin
			protect_on <= ~i_flash.option_byte[`FBG_OPT_PROTECT];
		end
	end

	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n)
			o_protect_on <= 1'b0;
		else
			o_protect_on <= protect_on;
	end

	// Parallel programmer gate
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_par_grant  <= 1'b0;
			o_par_refuse <= 1'b0;
		end else begin
			o_par_grant  <= i_par_req && !protect_on;
			o_par_refuse <= i_par_req && protect_on;
		end
	end

	// Stored ID taken as seven bytes from one flash info field
	fbg_id_compare u_cmp (
		.i_rx_id        (i_rx_id),
		.i_stored_id    (i_flash.stored_id),
		.i_reset_vector (i_flash.reset_vector),
		.i_protect_on   (protect_on),
		.o_result       (id_res)
	);

	// ID check result latched per serial session
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_id_checked <= 1'b0;
			id_pass      <= 1'b0;
			o_erase_all  <= 1'b0;
			o_serial_off <= 1'b0;
		end else begin
			o_erase_all <= 1'b0;
			if (o_mode == FBG_MODE_SERIAL && i_id_valid && !o_id_checked) begin
				o_id_checked <= 1'b1;
				id_pass      <= id_res.accept;
				o_erase_all  <= id_res.erase_all;
				o_serial_off <= id_res.serial_off;
			end
		end
	end

	// Command gate
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_cmd_accept <= 1'b0;
			o_cmd_reject <= 1'b0;
		end else begin
			o_cmd_accept <= i_cmd_valid && o_id_checked && id_pass && !o_serial_off;
			o_cmd_reject <= i_cmd_valid && !(o_id_checked && id_pass && !o_serial_off);
		end
	end

	// Address region selects
	always_ff @(posedge i_clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			o_rom2_sel       <= 1'b0;
			o_data_flash_sel <= 1'b0;
		end else begin
			o_rom2_sel <= !i_rom2_enable_bit && i_cpu_addr >= `FBG_ROM2_LO
				&& i_cpu_addr <= `FBG_ROM2_HI;
			o_data_flash_sel <= i_data_flash_map_bit && i_cpu_addr >= `FBG_DF_LO
				&& i_cpu_addr <= `FBG_DF_HI;
		end
	end

	// Checks
	a_boot_once: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		o_boot_done |=> $stable(o_mode)) else $error("mode changed after decision");
	a_user_start: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(o_boot_done && o_mode == FBG_MODE_USER) |-> o_start_addr == 20'h10000)
		else $error("user boot start wrong");
	a_par_block: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(i_par_req && protect_on) |=> (o_par_refuse && !o_par_grant))
		else $error("parallel access not refused");
	a_cmd_mismatch: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		(i_cmd_valid && !id_pass) |=> (o_cmd_reject && !o_cmd_accept))
		else $error("command accepted without ID match");
	a_serial_off: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		o_serial_off |-> !o_cmd_accept) else $error("serial off yet accepted");
	a_erase_pulse: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		o_erase_all |=> !o_erase_all) else $error("erase pulse too long");
	a_df_map: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		!i_data_flash_map_bit |=> !o_data_flash_sel) else $error("data flash mapped");
	a_rom2_gate: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		i_rom2_enable_bit |=> !o_rom2_sel) else $error("rom2 used while disabled");
	a_erase_unprot: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		i_block0_erased |=> !protect_on) else $error("protection kept after erase");
	a_no_sig: assert property (@(posedge i_clk_sys) disable iff (!rst_n)
		($rose(o_boot_done) && !i_boot_select_pin && i_processor_mode_pin && !sig_ok)
		|-> o_mode == FBG_MODE_SERIAL) else $error("bad signature not serial");
endmodule // fbg_guard
`default_nettype wire

// ==== tb/fbg_prog_model.sv ====
// Behavioural external programmer: ID codes, commands, parallel requests
`default_nettype none
module fbg_prog_model (
	input  wire logic        i_clk_sys,
	output var  logic        o_id_valid,
	output var  logic [55:0] o_rx_id,
	output var  logic        o_cmd_valid,
	output var  logic        o_par_req,
	output var  logic        o_block0_erased
);
	timeunit 1ns;
	timeprecision 1ps;
	// Idle lines at time zero
	initial begin
		o_id_valid = 1'b0;
		o_rx_id = 56'h0;
		o_cmd_valid = 1'b0;
		o_par_req = 1'b0;
		o_block0_erased = 1'b0;
	end
	// ID held one cycle, then the released bus shows the inverse
	task automatic send_id(input logic [55:0] id);
		@(posedge i_clk_sys);
		o_id_valid <= 1'b1;
		o_rx_id <= id;
		@(posedge i_clk_sys);
		o_id_valid <= 1'b0;
		o_rx_id <= ~id;
	endtask
	// One-cycle strobe: 0 command, 1 parallel request, 2 block 0 erase
	task automatic pulse(input int sel);
		@(posedge i_clk_sys);
		case (sel)
			0: o_cmd_valid <= 1'b1;
			1: o_par_req <= 1'b1;
			default: o_block0_erased <= 1'b1;
		endcase
		@(posedge i_clk_sys);
		{o_cmd_valid, o_par_req, o_block0_erased} <= 3'h0;
	endtask
endmodule // fbg_prog_model
`default_nettype wire

// ==== tb/fbg_guard_tb_top.sv ====
// Self-checking bench for the flash boot select and ID guard
`include "fbg_defines.svh"
`default_nettype none
module fbg_guard_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import fbg_pkg::*;
	logic            clk, rst_n, bsel, pmode, r2en, dfmap, done, acc, rej, ers, soff, idc, pgr, prf, prot, r2s, dfs;
	logic            id_v, cmd_v, preq, b0e;
	logic [55:0]     rx_id;
	logic [39:0]     ports;
	logic [19:0]     caddr, start;
	fbg_flash_info_t info;
	fbg_mode_t       mode;
	int              num_errors, check_count;
	localparam logic [55:0] SID = 56'h0123456789abcd;
	localparam logic [55:0] EW = `FBG_ERASE_WORD;
	fbg_guard DUT (.i_clk_sys(clk), .i_reset_n(rst_n), .i_boot_select_pin(bsel), .i_processor_mode_pin(pmode),
		.i_flash(info), .i_port_a(ports[39:32]), .i_port_b(ports[31:24]), .i_port_c(ports[23:16]),
		.i_port_d(ports[15:8]), .i_port_e(ports[7:0]), .i_id_valid(id_v), .i_rx_id(rx_id), .i_cmd_valid(cmd_v),
		.i_par_req(preq), .i_block0_erased(b0e), .i_rom2_enable_bit(r2en), .i_data_flash_map_bit(dfmap),
		.i_cpu_addr(caddr), .o_boot_done(done), .o_mode(mode), .o_start_addr(start), .o_cmd_accept(acc),
		.o_cmd_reject(rej), .o_erase_all(ers), .o_serial_off(soff), .o_id_checked(idc), .o_par_grant(pgr),
		.o_par_refuse(prf), .o_protect_on(prot), .o_rom2_sel(r2s), .o_data_flash_sel(dfs));
	fbg_prog_model PRG (.i_clk_sys(clk), .o_id_valid(id_v), .o_rx_id(rx_id), .o_cmd_valid(cmd_v),
		.o_par_req(preq), .o_block0_erased(b0e));
	// Clock at 50 MHz
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	// Compare any result widened to 20 bits
	task automatic chk(input logic [19:0] got, input logic [19:0] exp);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Flash contents in struct order
	function automatic fbg_flash_info_t mk(logic [63:0] s, logic [15:0] a, logic [7:0] b, logic [7:0] l,
		logic [55:0] id, logic [31:0] v, logic [7:0] o);
		return {s, a, b, l, id, v, o};
	endfunction
	// Reset with given pins and flash, wait for the decision
	task automatic boot(input logic b, input logic p, input fbg_flash_info_t f, input fbg_mode_t m);
		int n;
		n = 0;
		@(posedge clk);
		rst_n <= 1'b0;
		bsel <= b;
		pmode <= p;
		info <= f;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		while (done !== 1'b1 && n < 10) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(20'(done), 20'h1);
		chk(20'(mode), 20'(m));
	endtask
	// Pin combinations, signature and direct user boot
	task automatic t_boot();
		boot(1'b1, 1'b1, mk(`FBG_SIG_WORD, 16'h0, 8'h0, 8'h0, SID, 32'h0, 8'hff), FBG_MODE_NORMAL);
		@(posedge clk);
		bsel <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		chk(20'(mode), 20'(FBG_MODE_NORMAL));
		boot(1'b0, 1'b0, mk(`FBG_SIG_WORD, 16'h0, 8'h0, 8'h0, SID, 32'h0, 8'hff), FBG_MODE_NORMAL);
		boot(1'b0, 1'b1, mk(64'h55736572426f6f75, 16'h0, 8'h0, 8'h0, SID, 32'h0, 8'hff), FBG_MODE_SERIAL);
		boot(1'b0, 1'b1, mk(`FBG_SIG_WORD, 16'h0, 8'h0, 8'h0, SID, 32'h0, 8'hff), FBG_MODE_USER);
		chk(start, 20'h10000);
		boot(1'b0, 1'b1, mk(`FBG_SIG_WORD, 16'h0, 8'h0, 8'h0, `FBG_PROTECT_WORD, 32'h0, 8'hff), FBG_MODE_USER);
		boot(1'b0, 1'b1, mk(`FBG_SIG_WORD, 16'h03ea, 8'h0, 8'h0, SID, 32'h0, 8'hff), FBG_MODE_SERIAL);
		boot(1'b0, 1'b1, mk(`FBG_SIG_WORD, 16'h03e9, 8'h08, 8'h0, SID, 32'h0, 8'hff), FBG_MODE_SERIAL);
		$display("boot test done");
	endtask
	// Every entry port, both levels, both pin states
	task automatic t_ports();
		logic [15:0] adr [5] = '{16'h03e9, 16'h03ec, 16'h03ed, 16'h03f0, 16'h03f4};
		logic [39:0] p;
		int bn;
		for (int i = 0; i < 5; i++) begin
			for (int k = 0; k < 4; k++) begin
				bn = (i == 4) ? 7 : i;
				p = {40{~k[0]}};
				p[8*(4-i)+bn] = k[0];
				@(posedge clk);
				ports <= p;
				boot(1'b0, 1'b1, mk(`FBG_SIG_WORD, adr[i], 8'(bn), 8'(k >> 1), SID, 32'h0, 8'hff),
					(k[0] == k[1]) ? FBG_MODE_USER : FBG_MODE_SERIAL);
			end
		end
		$display("port test done");
	endtask
	// Serial session: early command, ID, then one command; exp is {erase, accept, serial_off}
	task automatic idcase(input logic [55:0] sid, input logic [31:0] v, input logic [7:0] o, input logic [55:0] rid,
		input logic [2:0] exp);
		boot(1'b0, 1'b1, mk(64'h0, 16'h0, 8'h0, 8'h0, sid, v, o), FBG_MODE_SERIAL);
		PRG.pulse(0);
		#1;
		chk(20'(rej), 20'h1);
		PRG.send_id(rid);
		#1;
		chk(20'(idc), 20'h1);
		chk(20'({ers, soff}), 20'({exp[2], exp[0]}));
		PRG.pulse(0);
		#1;
		chk(20'({acc, rej}), 20'({exp[1], ~exp[1]}));
	endtask
	// ID check, blank vector, forced erase and serial disable
	task automatic t_ids();
		idcase(SID, 32'h0, 8'hff, SID, 3'b010);
		idcase(SID, 32'h0, 8'hff, SID ^ 56'h1, 3'b000);
		idcase(SID, 32'h0, 8'hff, SID ^ {8'h80, 48'h0}, 3'b000);
		idcase(SID, 32'hffffffff, 8'hff, ~SID, 3'b010);
		idcase(EW, 32'h0, 8'hff, EW, 3'b110);
		idcase(EW, 32'h0, 8'hff, SID, 3'b000);
		idcase(SID, 32'h0, 8'hf7, EW, 3'b000);
		idcase(SID, 32'h0, 8'hff, EW, 3'b110);
		idcase(`FBG_PROTECT_WORD, 32'hffffffff, 8'hff, `FBG_PROTECT_WORD, 3'b001);
		$display("id test done");
	endtask
	// Parallel protection and its removal by erasing block 0
	task automatic t_par();
		boot(1'b1, 1'b1, mk(64'h0, 16'h0, 8'h0, 8'h0, SID, 32'h0, 8'hf7), FBG_MODE_NORMAL);
		// Protect status output lags the captured bit by one cycle
		@(posedge clk);
		#1;
		chk(20'(prot), 20'h1);
		PRG.pulse(1);
		#1;
		chk(20'({pgr, prf}), 20'h1);
		PRG.pulse(2);
		@(posedge clk);
		#1;
		chk(20'(prot), 20'h0);
		PRG.pulse(1);
		#1;
		chk(20'({pgr, prf}), 20'h2);
		$display("parallel test done");
	endtask
	// Region selects; exp is {rom2, data flash}
	task automatic mapcase(input logic [19:0] a, input logic en, input logic mp, input logic [1:0] exp);
		@(posedge clk);
		caddr <= a;
		r2en <= en;
		dfmap <= mp;
		@(posedge clk);
		#1;
		chk(20'({r2s, dfs}), 20'(exp));
	endtask
	// Region bounds with enable and map bits
	task automatic t_map();
		mapcase(20'h10000, 1'b0, 1'b0, 2'h2);
		mapcase(20'h13fff, 1'b1, 1'b0, 2'h0);
		mapcase(20'h0e000, 1'b0, 1'b1, 2'h1);
		mapcase(20'h0ffff, 1'b0, 1'b0, 2'h0);
		mapcase(20'h0dfff, 1'b0, 1'b1, 2'h0);
		mapcase(20'h13fff, 1'b0, 1'b1, 2'h2);
		mapcase(20'h0ffff, 1'b0, 1'b1, 2'h1);
		mapcase(20'h14000, 1'b0, 1'b1, 2'h0);
		$display("map test done");
	endtask
	// Counts and verdict
	task automatic test_done();
		$display("checks=%0d errors=%0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask
	// Watchdog far beyond the expected run
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
	// Main sequence
	initial begin
		{rst_n, bsel, pmode, r2en, dfmap} = 5'h06;
		info = '0;
		ports = 40'h0;
		caddr = 20'h0;
		num_errors = 0;
		check_count = 0;
		repeat (20) @(posedge clk);
		t_boot();
		t_ports();
		t_ids();
		t_par();
		t_map();
		test_done();
	end
endmodule // fbg_guard_tb_top
`default_nettype wire
